/* design/eeprom_consts.svh */
`ifndef EEPROM_CONSTS_SVH
`define EEPROM_CONSTS_SVH

// ----------------------------------------------------------------
// device address byte layout
// ----------------------------------------------------------------
`define DA_TYPE_CODE 4'ha
`define DA_TYPE_HI 7
`define DA_TYPE_LO 4
`define DA_ZERO_POS 3
`define DA_CS_HI_POS 2
`define DA_CS_LO_POS 1
`define DA_RW_POS 0

// ----------------------------------------------------------------
// bit slot counts within one nine-clock byte frame
// ----------------------------------------------------------------
`define BIT_FIRST 4'h0
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_DONE 4'h9

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define ADDR_W_DEF 15
`define ADDR_W_MIN 14
`define ADDR_W_MAX 15
`define PAGE_BITS 6
`define ADDR_ZERO 15'h0000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TWR_NS 5000000
`define REF_CLK_MHZ 250
`define NS_PER_US 1000

`endif

/* design/eeprom_pkg.sv */
package eeprom_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_ADDR_HI = 3'b010,
		ST_ADDR_LO = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101
	} link_st_e;

	typedef struct packed {
		link_st_e st;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic [7:0] tx;
		logic [14:0] addr;
		logic [7:0] hi;
		logic ack_pend;
		logic mack;
		logic wrote;
		logic busy;
		logic req_tgl;
		logic done_seen;
		logic scl_q;
		logic sda_q;
		logic sda_oe;
		logic sda_out;
		logic standby;
	} link_s;

	typedef struct packed {
		logic req_seen;
		logic active;
		logic [31:0] cnt;
		logic done_tgl;
	} tmr_s;

endpackage : eeprom_pkg

/* design/prog_if.sv */
`timescale 1ns/10ps
interface prog_if;
	logic req_sync;
	logic done_tgl;
	modport ctl (output req_sync, input done_tgl);
	modport tmr (input req_sync, output done_tgl);
endinterface : prog_if

/* design/prog_timer.sv */
`timescale 1ns/10ps
module prog_timer #(
	parameter int unsigned CYC = 1
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	prog_if.tmr bus
);
	if (CYC < 1) begin : g_chk
		$error("program cycle count must be at least one");
	end

	eeprom_pkg::tmr_s r;
	eeprom_pkg::tmr_s n;

	// one request toggle in, one done toggle out after CYC cycles
	always_comb begin
		n = r;
		if (bus.req_sync != r.req_seen) begin
			n.req_seen = bus.req_sync;
			n.active = 1'b1;
			n.cnt = 32'(CYC - 1);
		end else if (r.active) begin
			if (r.cnt == 32'h0000_0000) begin
				n.active = 1'b0;
				n.done_tgl = ~r.done_tgl;
			end else begin
				n.cnt = r.cnt - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign bus.done_tgl = r.done_tgl;
endmodule : prog_timer

/* design/serial_eeprom_two_wire_slave.sv */
// What this block does
// - data falling while clock high is start; recognised in any state except during the program cycle.
// - data rising while clock high is stop; standby after stop and idle program.
// - bits sampled on clock rise; driven data changes only after clock fall.
// - bytes are eight bits msb first; device pulls data low on ninth clock.
// - first byte after start is device address with fixed one-zero pattern.
// - two select bits must equal the strapped select pins as sampled; no pull applied.
// - lowest address bit high starts read, low starts write.
// - matching address gets ack; mismatch leaves line released, idle until start.
// - array holds 14 or 15 address bits; unused upper bits ignored.
// - byte write is address, two word bytes, one data byte, then stop.
// - during the self-timed program cycle all bus inputs ignored, no answer.
// - page write sends up to 64 data bytes, each acked, ended by stop.
// - writes step only the low six address bits, wrapping inside the page.
// - polling address is acked only after the program cycle has ended.
// - protect pin high blocks programming of the whole array.
// - address counter holds one past last byte accessed, kept between operations.
// - reads wrap from the last array byte to byte zero.
// - current read returns byte at counter; controller nacks and stops.
// - random read loads address by dummy write, then repeated start and read.
// - each controller ack sends the next byte; nack plus stop ends reads.
`timescale 1ns/10ps
`include "eeprom_consts.svh"
module serial_eeprom_two_wire_slave #(
	parameter int ADDR_W = `ADDR_W_DEF,
	parameter int unsigned TWR_CYCLES = `TWR_NS * `REF_CLK_MHZ / `NS_PER_US
) (
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	input wire logic i_link_clk,
	input wire logic i_scl,
	input wire logic i_sda_i,
	input wire logic i_wp,
	input wire logic i_chip_select_pin_low,
	input wire logic i_chip_select_pin_high,
	output logic o_sda_o,
	output logic o_sda_oe,
	output logic o_standby
);
	if (ADDR_W < `ADDR_W_MIN || ADDR_W > `ADDR_W_MAX) begin : g_chk
		$error("ADDR_W must be 14 or 15");
	end

	localparam int DEPTH = 1 << ADDR_W;
	localparam logic [14:0] ADDR_MASK = 15'(DEPTH - 1);

	// ----------------------------------------------------------------
	// pin and domain crossings
	// ----------------------------------------------------------------
	prog_if prog ();

	logic [6:0] pins_s;
	logic link_rst;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic cs_hi_s;
	logic cs_lo_s;
	logic done_s;

	eeprom_pkg::link_s r;
	eeprom_pkg::link_s n;

	sync2 #(.W(7)) u_link_sync (
		.i_clk(i_link_clk),
		.i_rst(1'b0),
		.i_d({i_sys_rst, i_scl, i_sda_i, i_wp, i_chip_select_pin_high,
			i_chip_select_pin_low, prog.done_tgl}),
		.o_q(pins_s)
	);

	assign {link_rst, scl_s, sda_s, wp_s, cs_hi_s, cs_lo_s, done_s} = pins_s;

	sync2 #(.W(1)) u_req_sync (
		.i_clk(i_ref_clk),
		.i_rst(i_sys_rst),
		.i_d(r.req_tgl),
		.o_q(prog.req_sync)
	);

	prog_timer #(.CYC(TWR_CYCLES)) u_timer (
		.i_ref_clk(i_ref_clk),
		.i_sys_rst(i_sys_rst),
		.bus(prog.tmr)
	);

	// ----------------------------------------------------------------
	// array
	// ----------------------------------------------------------------
	logic [7:0] mem [DEPTH];
	logic mem_we;
	logic [7:0] rd_byte;

	assign rd_byte = mem[r.addr[ADDR_W-1:0]];

	always_ff @(posedge i_link_clk) begin
		if (mem_we) begin
			mem[r.addr[ADDR_W-1:0]] <= {r.sh[6:0], sda_s};
		end
	end

	function automatic logic [14:0] rd_inc(input logic [14:0] a);
		rd_inc = (a + 15'h0001) & ADDR_MASK;
	endfunction : rd_inc

	function automatic logic [14:0] pg_inc(input logic [14:0] a);
		pg_inc = {a[14:`PAGE_BITS], a[`PAGE_BITS-1:0] + 6'h01};
	endfunction : pg_inc

	// ----------------------------------------------------------------
	// bus events
	// ----------------------------------------------------------------
	logic rise_w;
	logic fall_w;
	logic start_w;
	logic stop_w;
	logic [7:0] sh_in;
	logic dev_hit_w;

	assign rise_w = scl_s & ~r.scl_q;
	assign fall_w = ~scl_s & r.scl_q;
	assign start_w = scl_s & r.scl_q & r.sda_q & ~sda_s;
	assign stop_w = scl_s & r.scl_q & ~r.sda_q & sda_s;
	assign sh_in = {r.sh[6:0], sda_s};
	assign dev_hit_w = (sh_in[`DA_TYPE_HI:`DA_TYPE_LO] == `DA_TYPE_CODE)
		&& (sh_in[`DA_ZERO_POS] == 1'b0)
		&& (sh_in[`DA_CS_HI_POS] == cs_hi_s)
		&& (sh_in[`DA_CS_LO_POS] == cs_lo_s);

	// ----------------------------------------------------------------
	// protocol engine
	// ----------------------------------------------------------------
	always_comb begin
		n = r;
		mem_we = 1'b0;
		n.scl_q = scl_s;
		n.sda_q = sda_s;
		if (done_s != r.done_seen) begin
			n.done_seen = done_s;
			n.busy = 1'b0;
		end
		if (r.busy) begin
			n.st = eeprom_pkg::ST_IDLE;
			n.sda_oe = 1'b0;
		end else if (stop_w) begin
			n.st = eeprom_pkg::ST_IDLE;
			n.sda_oe = 1'b0;
			if (r.st == eeprom_pkg::ST_WDATA && r.wrote) begin
				n.busy = 1'b1;
				n.req_tgl = ~r.req_tgl;
			end
			n.wrote = 1'b0;
		end else if (start_w) begin
			n.st = eeprom_pkg::ST_DEV;
			n.bitn = `BIT_FIRST;
			n.sda_oe = 1'b0;
			n.ack_pend = 1'b0;
			n.wrote = 1'b0;
		end else if (r.st == eeprom_pkg::ST_RDATA) begin
			if (rise_w && r.bitn < `BIT_ACK) begin
				n.bitn = r.bitn + 4'h1;
				if (r.bitn == `BIT_LAST) begin
					n.addr = rd_inc(r.addr);
				end
			end else if (rise_w && r.bitn == `BIT_ACK) begin
				n.mack = ~sda_s;
				n.bitn = `BIT_DONE;
			end else if (fall_w && r.bitn < `BIT_ACK) begin
				n.sda_oe = ~r.tx[3'(`BIT_LAST - r.bitn)];
			end else if (fall_w && r.bitn == `BIT_ACK) begin
				n.sda_oe = 1'b0;
			end else if (fall_w && r.bitn == `BIT_DONE) begin
				n.bitn = `BIT_FIRST;
				if (r.mack) begin
					n.tx = rd_byte;
					n.sda_oe = ~rd_byte[7];
				end else begin
					n.st = eeprom_pkg::ST_IDLE;
					n.sda_oe = 1'b0;
				end
			end
		end else if (r.st != eeprom_pkg::ST_IDLE) begin
			if (rise_w && r.bitn < `BIT_ACK) begin
				n.sh = sh_in;
				n.bitn = r.bitn + 4'h1;
				if (r.bitn == `BIT_LAST) begin
					n.ack_pend = 1'b1;
					unique case (r.st)
						eeprom_pkg::ST_DEV: begin
							if (!dev_hit_w) begin
								n.st = eeprom_pkg::ST_IDLE;
								n.ack_pend = 1'b0;
							end
						end
						eeprom_pkg::ST_ADDR_HI: begin
							n.hi = sh_in;
						end
						eeprom_pkg::ST_ADDR_LO: begin
							n.addr = {r.hi[6:0], sh_in} & ADDR_MASK;
						end
						eeprom_pkg::ST_WDATA: begin
							n.addr = pg_inc(r.addr);
							if (!wp_s) begin
								mem_we = 1'b1;
								n.wrote = 1'b1;
							end
						end
						default: begin
						end
					endcase
				end
			end else if (rise_w && r.bitn == `BIT_ACK) begin
				n.bitn = `BIT_DONE;
			end else if (fall_w && r.bitn == `BIT_ACK) begin
				n.sda_oe = r.ack_pend;
			end else if (fall_w && r.bitn == `BIT_DONE) begin
				n.sda_oe = 1'b0;
				n.bitn = `BIT_FIRST;
				n.ack_pend = 1'b0;
				unique case (r.st)
					eeprom_pkg::ST_DEV: begin
						if (r.sh[`DA_RW_POS]) begin
							n.st = eeprom_pkg::ST_RDATA;
							n.tx = rd_byte;
							n.sda_oe = ~rd_byte[7];
						end else begin
							n.st = eeprom_pkg::ST_ADDR_HI;
						end
					end
					eeprom_pkg::ST_ADDR_HI: n.st = eeprom_pkg::ST_ADDR_LO;
					eeprom_pkg::ST_ADDR_LO: n.st = eeprom_pkg::ST_WDATA;
					default: n.st = r.st;
				endcase
			end
		end
		n.sda_out = 1'b0;
		n.standby = (n.st == eeprom_pkg::ST_IDLE) && !n.busy;
	end

	always_ff @(posedge i_link_clk) begin
		if (link_rst) begin
			r <= '0;
			r.st <= eeprom_pkg::ST_IDLE;
			r.addr <= `ADDR_ZERO;
			r.standby <= 1'b1;
			// edge history starts at the idle-high bus level: no false edge after reset
			r.scl_q <= 1'b1;
			r.sda_q <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign o_sda_o = r.sda_out;
	assign o_sda_oe = r.sda_oe;
	assign o_standby = r.standby;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_link_clk);
	endclocking
	default disable iff (link_rst);

	logic ctl_w;
	assign ctl_w = start_w | stop_w | r.busy;

	sequence s_byte_end;
		rise_w && (r.bitn == `BIT_LAST) && !r.busy;
	endsequence

	sequence s_dev_hit;
		(r.st == eeprom_pkg::ST_DEV) ##0 s_byte_end ##0 dev_hit_w;
	endsequence

	sequence s_dev_miss;
		(r.st == eeprom_pkg::ST_DEV) ##0 s_byte_end ##0 !dev_hit_w;
	endsequence

	start_to_dev_a : assert property (
		(start_w && !r.busy) |=> (r.st == eeprom_pkg::ST_DEV) && (r.bitn == `BIT_FIRST))
		else $error("start did not open a device address byte");

	stop_to_idle_a : assert property (
		(stop_w && !r.busy) |=> (r.st == eeprom_pkg::ST_IDLE) && (r.standby == !r.busy))
		else $error("stop did not return to idle");

	drive_on_fall_a : assert property (
		$changed(r.sda_oe) |-> ($past(fall_w) || $past(ctl_w)))
		else $error("data drive changed away from a clock fall");

	ack_ninth_a : assert property (
		(fall_w && r.bitn == `BIT_ACK && r.ack_pend && !r.busy
			&& r.st != eeprom_pkg::ST_RDATA) |=> r.sda_oe ##1 (r.sda_oe || fall_w || ctl_w))
		else $error("ack not driven in the ninth clock");

	dev_hit_a : assert property (
		s_dev_hit |=> r.ack_pend && (r.bitn == `BIT_ACK))
		else $error("matching device address not acknowledged");

	dev_miss_a : assert property (
		s_dev_miss |=> (r.st == eeprom_pkg::ST_IDLE) && !r.ack_pend && !r.sda_oe)
		else $error("mismatching device address not released");

	rw_select_a : assert property (
		(fall_w && r.bitn == `BIT_DONE && r.st == eeprom_pkg::ST_DEV && !r.busy)
			|=> (r.st == (r.sh[`DA_RW_POS] ? eeprom_pkg::ST_RDATA : eeprom_pkg::ST_ADDR_HI)))
		else $error("direction bit not honoured");

	busy_silent_a : assert property (
		r.busy |-> !r.sda_oe && (r.st == eeprom_pkg::ST_IDLE || $rose(r.busy)))
		else $error("bus answered during program cycle");

	page_wrap_a : assert property (
		((r.st == eeprom_pkg::ST_WDATA) ##0 s_byte_end)
			|=> (r.addr[14:`PAGE_BITS] == $past(r.addr[14:`PAGE_BITS]))
			&& (r.addr[`PAGE_BITS-1:0] == $past(r.addr[`PAGE_BITS-1:0]) + 6'h01))
		else $error("write address left its page");

	wp_block_a : assert property (
		(mem_we |-> !wp_s) and ($rose(r.busy) |-> $past(r.wrote)))
		else $error("protected array was programmed");

	read_wrap_a : assert property (
		((r.st == eeprom_pkg::ST_RDATA) ##0 s_byte_end)
			|=> r.addr == (($past(r.addr) + 15'h0001) & ADDR_MASK))
		else $error("read address did not step with wrap");

	read_release_a : assert property (
		(r.st == eeprom_pkg::ST_RDATA && fall_w && r.bitn == `BIT_ACK && !r.busy)
			|=> !r.sda_oe)
		else $error("data line not released for the controller ack");

	nack_end_a : assert property (
		(r.st == eeprom_pkg::ST_RDATA && fall_w && r.bitn == `BIT_DONE && !r.mack
			&& !r.busy) |=> (r.st == eeprom_pkg::ST_IDLE) && !r.sda_oe)
		else $error("read went on after a missing controller ack");

	busy_no_write_a : assert property (
		r.busy |-> !mem_we)
		else $error("array written during program cycle");

	no_cycle_a : assert property (
		(stop_w && !r.busy && !r.wrote) |=> !r.busy)
		else $error("program cycle without a stored byte");
endmodule : serial_eeprom_two_wire_slave

/* design/sync2.sv */
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_s;

	sync_s r;
	sync_s n;

	always_comb begin
		n.s1 = i_d;
		n.s2 = r.s1;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign o_q = r.s2;
endmodule : sync2

/* dv/ctl_model.sv */
`timescale 1ns/10ps
module ctl_model #(
	parameter int H = 6
) (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_oe
);
	// ----------------------------------------------------------------
	// bus controller: clock stands low between byte frames and high only when idle, data is open drain
	// ----------------------------------------------------------------
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick

	task automatic start();
		o_sda_oe <= 1'b0;
		tick(H);
		o_scl <= 1'b1;
		tick(H);
		o_sda_oe <= 1'b1;
		tick(H);
		o_scl <= 1'b0;
		tick(2);
	endtask : start

	task automatic stop();
		o_sda_oe <= 1'b1;
		tick(H);
		o_scl <= 1'b1;
		tick(H);
		o_sda_oe <= 1'b0;
		tick(H);
	endtask : stop

	// clocks the bus until data reads high with the clock high, then starts
	task automatic recover(output int n);
		n = 0;
		o_sda_oe <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			tick(H);
			o_scl <= 1'b1;
			tick(H);
			n++;
			if (i_sda === 1'b1) break;
			o_scl <= 1'b0;
		end
		start();
	endtask : recover

	// eight bits then the ninth clock; a one releases the line
	task automatic xfer(input logic [7:0] tx, input logic rel9, output logic [7:0] rx,
		output logic ack);
		logic [8:0] v;
		v = {tx, rel9};
		for (int i = 8; i >= 0; i--) begin
			o_sda_oe <= ~v[i];
			tick(H);
			o_scl <= 1'b1;
			tick(H);
			if (i > 0) rx[i-1] = i_sda;
			else ack = i_sda;
			o_scl <= 1'b0;
			tick(2);
		end
	endtask : xfer
endmodule : ctl_model

/* dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	localparam logic [7:0] DEV_W = 8'ha4;
	localparam logic [7:0] DEV_R = 8'ha5;
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic wp = 1'b0;
	logic cs_hi = 1'b1;
	logic cs_lo = 1'b0;
	logic scl;
	logic m_oe;
	logic d_oe;
	logic d_o;
	logic stby;
	logic sda_w;
	logic ack;
	logic [7:0] rx;
	int n_errors = 0;
	int samples_checked = 0;

	// ----------------------------------------------------------------
	// clocks, wire and instances
	// ----------------------------------------------------------------
	always #2 ref_clk = ~ref_clk;
	always #7.5 link_clk = ~link_clk;
	assign sda_w = (m_oe || (d_oe && !d_o)) ? 1'b0 : 1'b1;

	serial_eeprom_two_wire_slave #(.ADDR_W(15), .TWR_CYCLES(2000)) DUT (
		.i_ref_clk(ref_clk), .i_sys_rst(rst), .i_link_clk(link_clk), .i_scl(scl),
		.i_sda_i(sda_w), .i_wp(wp), .i_chip_select_pin_low(cs_lo),
		.i_chip_select_pin_high(cs_hi), .o_sda_o(d_o), .o_sda_oe(d_oe), .o_standby(stby));
	ctl_model ctl (.i_clk(link_clk), .i_sda(sda_w), .o_scl(scl), .o_sda_oe(m_oe));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out

	task automatic put(input logic [7:0] b);
		ctl.xfer(b, 1'b1, rx, ack);
		chk(ack === 1'b0, "byte not acknowledged");
	endtask : put

	task automatic addr_phase(input logic [15:0] a);
		ctl.start();
		put(DEV_W);
		put(a[15:8]);
		put(a[7:0]);
	endtask : addr_phase

	task automatic rd_begin(input logic [15:0] a);
		addr_phase(a);
		ctl.start();
		put(DEV_R);
	endtask : rd_begin

	task automatic rd_cmp(input logic [7:0] e, input logic last);
		ctl.xfer(8'hff, last, rx, ack);
		chk(rx === e, "read data");
		if (last) begin
			ctl.stop();
			@(negedge link_clk);
			chk(stby === 1'b1, "no standby after read");
		end
	endtask : rd_cmp

	task automatic write_bytes(input logic [15:0] a, input logic [7:0] d[$]);
		addr_phase(a);
		foreach (d[i]) put(d[i]);
		ctl.stop();
	endtask : write_bytes

	// polls until the address is answered, bounded
	task automatic wait_ready();
		for (int i = 0; i < 40; i++) begin
			ctl.start();
			ctl.xfer(DEV_W, 1'b1, rx, ack);
			ctl.stop();
			if (ack === 1'b0) return;
		end
		chk(1'b0, "device stayed busy");
		close_out();
	endtask : wait_ready

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_write_poll();
		write_bytes(16'h0123, '{8'h5a});
		@(negedge link_clk);
		chk(stby === 1'b0, "no program cycle");
		ctl.start();
		ctl.xfer(DEV_W, 1'b1, rx, ack);
		ctl.stop();
		chk(ack === 1'b1, "answered while busy");
		wait_ready();
		rd_begin(16'h0123);
		rd_cmp(8'h5a, 1'b1);
		$display("test write_poll done");
	endtask : t_write_poll

	task automatic t_page_wrap();
		write_bytes(16'h0a3e, '{8'hd0, 8'hd1, 8'hd2, 8'hd3});
		wait_ready();
		rd_begin(16'h0a00);
		rd_cmp(8'hd2, 1'b1);
		ctl.start();
		put(DEV_R);
		rd_cmp(8'hd3, 1'b1);
		rd_begin(16'h0a3e);
		rd_cmp(8'hd0, 1'b0);
		rd_cmp(8'hd1, 1'b1);
		$display("test page_wrap done");
	endtask : t_page_wrap

	task automatic t_array_wrap();
		write_bytes(16'h7fff, '{8'h77});
		wait_ready();
		write_bytes(16'h0000, '{8'h11});
		wait_ready();
		rd_begin(16'hffff);
		rd_cmp(8'h77, 1'b0);
		rd_cmp(8'h11, 1'b1);
		$display("test array_wrap done");
	endtask : t_array_wrap

	task automatic t_protect();
		@(posedge ref_clk);
		wp <= 1'b1;
		write_bytes(16'h0123, '{8'hc3});
		@(negedge link_clk);
		chk(stby === 1'b1, "program cycle while protected");
		@(posedge ref_clk);
		wp <= 1'b0;
		rd_begin(16'h0123);
		rd_cmp(8'h5a, 1'b1);
		$display("test protect done");
	endtask : t_protect

	// device is left driving a low data bit in mid-read, then the bus is recovered
	task automatic t_recover();
		int n;
		rd_begin(16'h0123);
		ctl.recover(n);
		chk(n === 2, "recovery clock count");
		put(DEV_R);
		rd_cmp(8'h5a, 1'b1);
		$display("test recover done");
	endtask : t_recover

	task automatic t_mismatch();
		logic [7:0] bad [6] = '{8'ha0, 8'ha6, 8'ha2, 8'hac, 8'hb4, 8'he4};
		foreach (bad[i]) begin
			ctl.start();
			ctl.xfer(bad[i], 1'b1, rx, ack);
			chk(ack === 1'b1, "wrong address answered");
			ctl.xfer(DEV_W, 1'b1, rx, ack);
			chk(ack === 1'b1, "answered without start");
			ctl.stop();
		end
		@(posedge ref_clk);
		cs_hi <= 1'b0;
		cs_lo <= 1'b1;
		repeat (8) @(posedge ref_clk);
		ctl.start();
		put(8'ha2);
		ctl.stop();
		@(posedge ref_clk);
		cs_hi <= 1'b1;
		cs_lo <= 1'b0;
		$display("test mismatch done");
	endtask : t_mismatch

	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (8) @(posedge link_clk);
		@(negedge link_clk);
		chk(stby === 1'b1 && d_oe === 1'b0 && d_o === 1'b0, "reset state");
		t_write_poll();
		t_page_wrap();
		t_array_wrap();
		t_protect();
		t_recover();
		t_mismatch();
		close_out();
	end
endmodule : tb_top
